// ===== design/dppa_top.sv
`timescale 1ns/1ps
module dppa_top
  import dppa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_phase_clock,
  input wire logic chip_sel_high_a,
  input wire logic chip_sel_high_b,
  input wire logic chip_sel_low_n,
  input wire logic read_not_write,
  input wire logic reg_sel_low,
  input wire logic reg_sel_high,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] port_a_lines_in,
  output logic [7:0] port_a_lines_out,
  output logic [7:0] port_a_lines_oe_n,
  input wire logic [7:0] port_b_lines_in,
  output logic [7:0] port_b_lines_out,
  output logic [7:0] port_b_lines_oe_n,
  input wire logic port_a_strobe_in,
  input wire logic port_b_strobe_in,
  input wire logic port_a_control_line_in,
  output logic port_a_control_line_out,
  output logic port_a_control_line_oe_n,
  input wire logic port_b_control_line_in,
  output logic port_b_control_line_out,
  output logic port_b_control_line_oe_n,
  output logic side_a_irq_n_out,
  output logic side_a_irq_oe_n,
  output logic side_b_irq_n_out,
  output logic side_b_irq_oe_n
);
  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_pipe_r;
  logic rst_n_s;

  // Reset asserts at once but leaves only on a clock edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_pipe_r[1];

  logic [14:0] bus_raw;
  logic [14:0] bus_s;
  logic [14:0] bus_fall;
  logic [15:0] pins_s;
  logic [3:0] ctl_raw;
  logic [3:0] ctl_rise;
  logic [3:0] ctl_fall;

  // All bus pins share one delay so they stay aligned to the phase clock.
  assign bus_raw = {bus_phase_clock, chip_sel_high_a, chip_sel_high_b,
                    chip_sel_low_n, read_not_write, reg_sel_high,
                    reg_sel_low, data_in};
  assign ctl_raw = {port_b_control_line_in, port_a_control_line_in,
                    port_b_strobe_in, port_a_strobe_in};

  dppa_sync #(.W(15)) u_bus_sync (
    .clk(clk),
    .rst_n(rst_n_s),
    .d(bus_raw),
    .q(bus_s),
    .rise(),
    .fall(bus_fall)
  );

  dppa_sync #(.W(16)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n_s),
    .d({port_b_lines_in, port_a_lines_in}),
    .q(pins_s),
    .rise(),
    .fall()
  );

  dppa_sync #(.W(4)) u_ctl_sync (
    .clk(clk),
    .rst_n(rst_n_s),
    .d(ctl_raw),
    .q(),
    .rise(ctl_rise),
    .fall(ctl_fall)
  );

  logic phase_s;
  logic phase_fall;
  logic sel_s;
  logic rd_s;
  logic [1:0] rs_s;
  logic [7:0] dbus_s;

  assign phase_s = bus_s[14];
  assign phase_fall = bus_fall[14];
  assign sel_s = bus_s[13] & bus_s[12] & ~bus_s[11];
  assign rd_s = bus_s[10];
  assign rs_s = bus_s[9:8];
  assign dbus_s = bus_s[7:0];

  // ****************************************
  // Bus cycle latch and commit decode
  // ****************************************
  logic [7:0] hold_r;
  logic acc_sel_r;
  logic acc_rd_r;
  logic [1:0] acc_rs_r;

  // Holding latch tracks the bus while the phase clock is high.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hold_r <= RST_REG;
      acc_sel_r <= 1'b0;
      acc_rd_r <= 1'b0;
      acc_rs_r <= 2'h0;
    end else if (phase_s) begin
      hold_r <= dbus_s;
      acc_sel_r <= sel_s;
      acc_rd_r <= rd_s;
      acc_rs_r <= rs_s;
    end
  end

  logic [5:0] ctl_r [0:1];
  logic [7:0] dir_r [0:1];
  logic [7:0] out_r [0:1];
  logic [1:0] flag_str_r;
  logic [1:0] flag_cl_r;
  logic [1:0] cl_out_r;
  logic commit;
  logic acc_side;
  logic acc_data;
  logic [1:0] wr_ctl;
  logic [1:0] wr_dir;
  logic [1:0] wr_out;
  logic [1:0] rd_data;

  // Select code picks side and register; commit on phase fall.
  assign commit = phase_fall & acc_sel_r;
  assign acc_side = acc_rs_r[1];
  assign acc_data = ~acc_rs_r[0];
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      wr_ctl[s] = commit & ~acc_rd_r & (acc_side == s[0]) & ~acc_data;
      // Bit 2 steers data versus direction.
      wr_dir[s] = commit & ~acc_rd_r & (acc_side == s[0]) & acc_data
                  & ~ctl_r[s][CTL_DATA_SEL];
      wr_out[s] = commit & ~acc_rd_r & (acc_side == s[0]) & acc_data
                  & ctl_r[s][CTL_DATA_SEL];
      rd_data[s] = commit & acc_rd_r & (acc_side == s[0]) & acc_data
                   & ctl_r[s][CTL_DATA_SEL];
    end
  end

  // ****************************************
  // Register file, one set per side
  // ****************************************
  // Reset clears everything; sides kept apart.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      for (int s = 0; s < 2; s++) begin
        ctl_r[s] <= RST_CTL;
        dir_r[s] <= RST_REG;
        out_r[s] <= RST_REG;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        // Commit the held byte after the falling edge.
        if (wr_ctl[s]) begin
          ctl_r[s] <= hold_r[5:0];
        end
        if (wr_dir[s]) begin
          dir_r[s] <= hold_r;
        end
        if (wr_out[s]) begin
          out_r[s] <= hold_r;
        end
      end
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  logic [1:0] str_edge;
  logic [1:0] cl_edge;

  // Strobe edge choice; control line edge choice.
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      str_edge[s] = ctl_r[s][CTL_STR_EDGE] ? ctl_rise[s] : ctl_fall[s];
      cl_edge[s] = ctl_r[s][CTL_CL_B4] ? ctl_rise[s+2] : ctl_fall[s+2];
    end
  end

  // A new edge in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      flag_str_r <= 2'h0;
      flag_cl_r <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        // Strobe edge sets bit 7 regardless of enables.
        if (str_edge[s]) begin
          flag_str_r[s] <= 1'b1;
        end else if (rd_data[s]) begin
          flag_str_r[s] <= 1'b0;
        end
        // Input mode edge sets bit 6.
        if (cl_edge[s] & ~ctl_r[s][CTL_CL_DIR]) begin
          flag_cl_r[s] <= 1'b1;
        end else if (rd_data[s]) begin
          flag_cl_r[s] <= 1'b0;
        end
      end
    end
  end

  logic [1:0] irq_req;
  logic [1:0] irq_oe_n_r;

  // Each flag gated by its own enable bit.
  assign irq_req[0] = (flag_str_r[0] & ctl_r[0][CTL_STR_EN])
                    | (flag_cl_r[0] & ctl_r[0][CTL_CL_B3]);
  assign irq_req[1] = (flag_str_r[1] & ctl_r[1][CTL_STR_EN])
                    | (flag_cl_r[1] & ctl_r[1][CTL_CL_B3]);

  // Open drain: pull low only, otherwise release the wire.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_oe_n_r <= 2'h3;
    end else begin
      irq_oe_n_r <= ~irq_req;
    end
  end

  // ****************************************
  // Control line output modes
  // ****************************************
  logic [1:0] cl_trig;

  // Side A pulses on any selection; side B on output write.
  // Side A handshake triggers on data read; side B on write.
  always_comb begin
    cl_trig[0] = ctl_r[0][CTL_CL_B3] ? commit : rd_data[0];
    cl_trig[1] = wr_out[1];
  end

  // A trigger that meets a strobe edge in one cycle drives the line low.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cl_out_r <= 2'h3;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (!ctl_r[s][CTL_CL_DIR]) begin
          cl_out_r[s] <= 1'b1;
        end else if (ctl_r[s][CTL_CL_B4]) begin
          cl_out_r[s] <= ctl_r[s][CTL_CL_B3];
        end else if (cl_trig[s]) begin
          cl_out_r[s] <= 1'b0;
        // Pulse ends at the next phase fall.
        end else if (ctl_r[s][CTL_CL_B3]) begin
          if (phase_fall) begin
            cl_out_r[s] <= 1'b1;
          end
        // Handshake mode; strobe edge returns line high.
        end else if (str_edge[s]) begin
          cl_out_r[s] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Pin drivers and read data
  // ****************************************
  logic [7:0] line_oe_n_r [0:1];
  logic [1:0] cl_oe_n_r;

  // One direction bit per line; enables lag the register by a cycle.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      line_oe_n_r[0] <= 8'hFF;
      line_oe_n_r[1] <= 8'hFF;
      cl_oe_n_r <= 2'h3;
    end else begin
      line_oe_n_r[0] <= ~dir_r[0];
      line_oe_n_r[1] <= ~dir_r[1];
      cl_oe_n_r <= {~ctl_r[1][CTL_CL_DIR], ~ctl_r[0][CTL_CL_DIR]};
    end
  end

  logic [7:0] rd_mux;
  logic [7:0] data_out_r;
  logic data_oe_n_r;

  // Control reads carry both flags; B outputs read from the latch.
  always_comb begin
    unique case (rs_s)
      RS_A_DATA: rd_mux = ctl_r[0][CTL_DATA_SEL] ? pins_s[7:0] : dir_r[0];
      RS_A_CTL: rd_mux = {flag_str_r[0], flag_cl_r[0], ctl_r[0]};
      RS_B_DATA: rd_mux = ctl_r[1][CTL_DATA_SEL]
                 ? ((out_r[1] & dir_r[1]) | (pins_s[15:8] & ~dir_r[1]))
                 : dir_r[1];
      RS_B_CTL: rd_mux = {flag_str_r[1], flag_cl_r[1], ctl_r[1]};
    endcase
  end

  // The data bus is driven only in a selected read phase.
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      data_out_r <= RST_REG;
      data_oe_n_r <= 1'b1;
    end else begin
      data_out_r <= rd_mux;
      data_oe_n_r <= ~(phase_s & sel_s & rd_s);
    end
  end

  assign data_out = data_out_r;
  assign data_oe_n = data_oe_n_r;
  assign port_a_lines_out = out_r[0];
  assign port_b_lines_out = out_r[1];
  assign port_a_lines_oe_n = line_oe_n_r[0];
  assign port_b_lines_oe_n = line_oe_n_r[1];
  assign port_a_control_line_out = cl_out_r[0];
  assign port_b_control_line_out = cl_out_r[1];
  assign port_a_control_line_oe_n = cl_oe_n_r[0];
  assign port_b_control_line_oe_n = cl_oe_n_r[1];
  // The open-drain data level is a constant low flip-flop output.
  logic irq_low_r;
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_low_r <= 1'b0;
    end else begin
      irq_low_r <= 1'b0;
    end
  end
  assign side_a_irq_n_out = irq_low_r;
  assign side_b_irq_n_out = irq_low_r;
  assign side_a_irq_oe_n = irq_oe_n_r[0];
  assign side_b_irq_oe_n = irq_oe_n_r[1];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  sequence read_a_hs_s;
    rd_data[0] && ctl_r[0][5:3] == 3'h4;
  endsequence
  sequence write_b_pulse_s;
    wr_out[1] && ctl_r[1][5:3] == 3'h5;
  endsequence

  // Reset leaves port lines as inputs.
  reset_inputs_a: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n_s |=> port_a_lines_oe_n == 8'hFF && port_b_lines_oe_n == 8'hFF)
    else $error("port lines driven after reset");
  strobe_flag_a: assert property (str_edge[0] |=> flag_str_r[0])
    else $error("strobe edge did not set flag");
  // Input mode edge sets control flag.
  cl_flag_a: assert property (
    cl_edge[0] && !ctl_r[0][CTL_CL_DIR] |=> flag_cl_r[0])
    else $error("control line edge did not set flag");
  read_clear_a: assert property (
    rd_data[0] && !str_edge[0] && !cl_edge[0]
    |=> !flag_str_r[0] && !flag_cl_r[0])
    else $error("port read did not clear flags");
  irq_gate_a: assert property (
    ##1 side_a_irq_oe_n == !$past(irq_req[0]))
    else $error("interrupt output mismatch");
  // Direction register A only changes in the cycle after a phase fall.
  commit_fall_a: assert property (
    $changed(dir_r[0]) |-> $past(phase_fall))
    else $error("register changed outside phase fall");
  // Handshake read drives line low on the next cycle.
  hs_low_a: assert property (
    read_a_hs_s ##1 !str_edge[0] |-> !port_a_control_line_out)
    else $error("handshake read did not lower line");
  // Manual mode line follows bit 3.
  manual_out_a: assert property (
    ctl_r[0][CTL_CL_DIR] && ctl_r[0][CTL_CL_B4]
    |=> port_a_control_line_out == $past(ctl_r[0][CTL_CL_B3]))
    else $error("manual output mismatch");
  // Port B output write in pulse mode lowers line.
  b_pulse_a: assert property (write_b_pulse_s |=> !cl_out_r[1])
    else $error("port B pulse missing");
endmodule // dppa_top

// ===== design/dppa_pkg.sv
// Function
// - Reset clears registers, all port lines inputs.
// - Two independent sides, each with full register set.
// - Control bit 2 picks output or direction register.
// - Direction bit one means output, zero input.
// - Write latched in phase, committed after falling edge.
// - Strobe A edge always sets control A bit 7.
// - Control A bit 1 picks strobe A edge.
// - Control line input edge sets flag bit 6.
// - Pulse mode: control line A pulses per selection.
// - Handshake A: port A read drives line low.
// - Handshake A: strobe A edge returns line high.
// - Manual mode: control line follows bit 3.
// - Strobe B mirrors strobe A, sets bit 7.
// - Control line B input mirrors side A.
// - Pulse mode B: pulse on output register write.
// - Handshake B paces outbound data transfers.
// - Each side has open-drain active-low interrupt output.
// - Side A interrupt gated by bits 0 and 3.
// - Port A data read clears flags 6 and 7.
// - Side B interrupt and flag clear mirror A.
// - Flag bits readable in control registers.
// - Select codes map data/direction and control registers.
// - Transfers only when device selected.
package dppa_pkg;
  localparam int DW = 8;
  // Control register field positions.
  localparam int CTL_STR_EN = 0;
  localparam int CTL_STR_EDGE = 1;
  localparam int CTL_DATA_SEL = 2;
  localparam int CTL_CL_B3 = 3;
  localparam int CTL_CL_B4 = 4;
  localparam int CTL_CL_DIR = 5;
  localparam int CTL_FLAG_CL = 6;
  localparam int CTL_FLAG_STR = 7;
  // Register select codes.
  localparam logic [1:0] RS_A_DATA = 2'h0;
  localparam logic [1:0] RS_A_CTL = 2'h1;
  localparam logic [1:0] RS_B_DATA = 2'h2;
  localparam logic [1:0] RS_B_CTL = 2'h3;
  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [5:0] RST_CTL = 6'h00;
endpackage

// ===== design/dppa_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser with edge detect
// ****************************************
module dppa_sync
  import dppa_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [2:0] arm_r;

  // The first stage feeds only the second, so metastability stays put.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges stay masked until prev_r holds a real sample, so that a pin
  // idling high is not taken for a rising edge just after reset.
  // An edge in the first cycle after reset is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= 3'h0;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // Edges are judged on settled samples only.
  assign q = sync_r;
  assign rise = sync_r & ~prev_r & {W{arm_r[2]}};
  assign fall = ~sync_r & prev_r & {W{arm_r[2]}};
endmodule // dppa_sync

// ===== tb/dppa_periph.sv
`timescale 1ns/1ps
// ****************************************
// Peripheral side model
// ****************************************
module dppa_periph (
  input wire logic [7:0] pa_drive,
  input wire logic [7:0] pb_drive,
  input wire logic ca_level,
  input wire logic cb_level,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe_n,
  input wire logic ca_out,
  input wire logic ca_oe_n,
  input wire logic cb_out,
  input wire logic cb_oe_n,
  output logic [7:0] pa_pin,
  output logic [7:0] pb_pin,
  output logic ca_pin,
  output logic cb_pin
);
  // Each pin shows the device's level where it drives, else the peripheral.
  // The peripheral never fights a driven line, so no contention is modelled.
  // per line direction
  assign pa_pin = (pa_out & ~pa_oe_n) | (pa_drive & pa_oe_n);
  assign pb_pin = (pb_out & ~pb_oe_n) | (pb_drive & pb_oe_n);
  assign ca_pin = ca_oe_n ? ca_level : ca_out;
  assign cb_pin = cb_oe_n ? cb_level : cb_out;
endmodule // dppa_periph

// ===== tb/dual_port_parallel_adapter_bench.sv
`timescale 1ns/1ps
module dual_port_parallel_adapter_bench;
  import dppa_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, bus_phase_clock = 1'b0;
  logic chip_sel_low_n = 1'b1, read_not_write = 1'b1;
  logic reg_sel_low = 1'b0, reg_sel_high = 1'b0;
  logic [7:0] data_in = 8'h00, pa_drive = 8'hFF, pb_drive = 8'hFF, v;
  logic [1:0] str_lv = 2'h3, cl_lv = 2'h3;
  logic [7:0] data_out, pa_out, pa_oe_n, pb_out, pb_oe_n, pa_pin, pb_pin;
  logic data_oe_n, ca_out, ca_oe_n, cb_out, cb_oe_n, ca_pin, cb_pin;
  logic irq_a_n, irq_a_oe_n, irq_b_n, irq_b_oe_n, oe_seen;
  int err_count = 0, checked = 0;
  // ****************************************
  // Clock and structure
  // ****************************************
  // The 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  dppa_top DUT (.clk(clk), .rstn(rstn), .bus_phase_clock(bus_phase_clock),
    .chip_sel_high_a(1'b1), .chip_sel_high_b(1'b1),
    .chip_sel_low_n(chip_sel_low_n), .read_not_write(read_not_write),
    .reg_sel_low(reg_sel_low), .reg_sel_high(reg_sel_high),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .port_a_lines_in(pa_pin), .port_a_lines_out(pa_out),
    .port_a_lines_oe_n(pa_oe_n), .port_b_lines_in(pb_pin),
    .port_b_lines_out(pb_out), .port_b_lines_oe_n(pb_oe_n),
    .port_a_strobe_in(str_lv[0]), .port_b_strobe_in(str_lv[1]),
    .port_a_control_line_in(ca_pin), .port_a_control_line_out(ca_out),
    .port_a_control_line_oe_n(ca_oe_n), .port_b_control_line_in(cb_pin),
    .port_b_control_line_out(cb_out), .port_b_control_line_oe_n(cb_oe_n),
    .side_a_irq_n_out(irq_a_n), .side_a_irq_oe_n(irq_a_oe_n),
    .side_b_irq_n_out(irq_b_n), .side_b_irq_oe_n(irq_b_oe_n));
  dppa_periph PERIPH (.pa_drive(pa_drive), .pb_drive(pb_drive),
    .ca_level(cl_lv[0]), .cb_level(cl_lv[1]), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .ca_out(ca_out),
    .ca_oe_n(ca_oe_n), .cb_out(cb_out), .cb_oe_n(cb_oe_n), .pa_pin(pa_pin),
    .pb_pin(pb_pin), .ca_pin(ca_pin), .cb_pin(cb_pin));
  // ****************************************
  // Shared tasks
  // ****************************************
  // One processor cycle; the select stays up through the phase fall,
  // because the write only commits once that fall is seen.
  task automatic bus(input logic sel, input logic rd, input logic [1:0] rs,
    input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk);
    #5;
    chip_sel_low_n = ~sel;
    read_not_write = rd;
    reg_sel_high = rs[1];
    reg_sel_low = rs[0];
    data_in = wd;
    bus_phase_clock = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    q = data_out;
    oe_seen = data_oe_n;
    bus_phase_clock = 1'b0;
    repeat (6) @(posedge clk);
    #5;
    chip_sel_low_n = 1'b1;
  endtask
  // Lets a link edge pass its synchroniser and reach the flags.
  task automatic settle();
    repeat (8) @(posedge clk);
    #5;
  endtask
  task automatic chk(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Everything reads zero and every line floats after reset.
  task automatic t_reset();
    chk("pa oe", pa_oe_n, 8'hFF);
    chk("pb oe", pb_oe_n, 8'hFF);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 1'b1, r[1:0], 8'h00, v);
      chk("reset reg", v, RST_REG);
    end
    chk("data oe", {7'h0, oe_seen}, 8'h00);
    chk("bus idle", {7'h0, data_oe_n}, 8'h01);
    chk("irq level", {6'h0, irq_a_n, irq_b_n}, 8'h00);
    $display("t_reset done");
  endtask
  // Mixed directions on both ports; port B reads its latch on outputs.
  task automatic t_dir();
    bus(1'b1, 1'b0, RS_A_DATA, 8'hF0, v);
    bus(1'b1, 1'b0, RS_B_DATA, 8'h0F, v);
    bus(1'b1, 1'b1, RS_A_DATA, 8'h00, v);
    chk("ddr a", v, 8'hF0);
    bus(1'b1, 1'b0, RS_A_CTL, 8'h04, v);
    bus(1'b1, 1'b0, RS_B_CTL, 8'h04, v);
    bus(1'b1, 1'b0, RS_A_DATA, 8'hA5, v);
    bus(1'b1, 1'b0, RS_B_DATA, 8'h5A, v);
    chk("pa oe", pa_oe_n, 8'h0F);
    chk("pa out", pa_out, 8'hA5);
    chk("pb out", pb_out, 8'h5A);
    chk("pb oe", pb_oe_n, 8'hF0);
    pa_drive = 8'h3C;
    pb_drive = 8'hC3;
    bus(1'b1, 1'b1, RS_A_DATA, 8'h00, v);
    chk("pa read", v, 8'hAC);
    bus(1'b1, 1'b1, RS_B_DATA, 8'h00, v);
    chk("pb read", v, 8'hCA);
    $display("t_dir done");
  endtask
  // Both edges of both inputs, wrong edge first, then masking and clear.
  task automatic t_flags(input int s);
    logic [1:0] rc;
    logic [1:0] rdat;
    logic e1;
    logic [7:0] m;
    rc = s[0] ? RS_B_CTL : RS_A_CTL;
    rdat = s[0] ? RS_B_DATA : RS_A_DATA;
    for (int e = 0; e < 2; e++) begin
      e1 = e[0];
      m = {3'h0, e1, 2'h1, e1, 1'h0};
      str_lv[s] = e1;
      cl_lv[s] = e1;
      bus(1'b1, 1'b0, rc, m | 8'hC1, v);
      // The level change above may be an active edge; clear its flags.
      bus(1'b1, 1'b1, rdat, 8'h00, v);
      str_lv[s] = ~e1;
      cl_lv[s] = ~e1;
      settle();
      bus(1'b1, 1'b1, rc, 8'h00, v);
      chk("wrong edge", v, m | 8'h01);
      str_lv[s] = e1;
      cl_lv[s] = e1;
      settle();
      chk("irq str", {7'h0, s[0] ? irq_b_oe_n : irq_a_oe_n}, 8'h00);
      bus(1'b1, 1'b1, rc, 8'h00, v);
      chk("flags", v, m | 8'hC1);
      bus(1'b1, 1'b0, rc, m, v);
      chk("irq mask", {7'h0, s[0] ? irq_b_oe_n : irq_a_oe_n}, 8'h01);
      bus(1'b1, 1'b0, rc, m | 8'h08, v);
      chk("irq cl", {7'h0, s[0] ? irq_b_oe_n : irq_a_oe_n}, 8'h00);
      bus(1'b1, 1'b1, rdat, 8'h00, v);
      bus(1'b1, 1'b1, rc, 8'h00, v);
      chk("cleared", v, m | 8'h08);
      chk("irq off", {7'h0, s[0] ? irq_b_oe_n : irq_a_oe_n}, 8'h01);
    end
    $display("t_flags side %0d done", s);
  endtask
  // Manual mode of control line A; handshake and pulse output modes of both control lines.
  task automatic t_cl_out();
    bus(1'b1, 1'b0, RS_A_CTL, 8'h34, v);
    chk("ca man lo", {6'h0, ca_oe_n, ca_out}, 8'h00);
    bus(1'b1, 1'b0, RS_A_CTL, 8'h3C, v);
    chk("ca man hi", {6'h0, ca_oe_n, ca_out}, 8'h01);
    str_lv = 2'h3;
    bus(1'b1, 1'b0, RS_A_CTL, 8'h24, v);
    bus(1'b1, 1'b1, RS_A_DATA, 8'h00, v);
    chk("ca hs lo", {7'h0, ca_out}, 8'h00);
    str_lv[0] = 1'b0;
    settle();
    chk("ca hs hi", {7'h0, ca_out}, 8'h01);
    bus(1'b1, 1'b0, RS_B_CTL, 8'h24, v);
    bus(1'b1, 1'b0, RS_B_DATA, 8'h11, v);
    chk("cb hs lo", {7'h0, cb_out}, 8'h00);
    str_lv[1] = 1'b0;
    settle();
    chk("cb hs hi", {7'h0, cb_out}, 8'h01);
    bus(1'b1, 1'b0, RS_A_CTL, 8'h2C, v);
    bus(1'b1, 1'b1, RS_A_CTL, 8'h00, v);
    // Bit 7 is still set by the strobe edge of the handshake step.
    chk("ca ctl", v, 8'hAC);
    chk("ca pulse", {7'h0, ca_out}, 8'h00);
    bus(1'b0, 1'b0, RS_A_CTL, 8'h00, v);
    chk("ca pulse end", {7'h0, ca_out}, 8'h01);
    bus(1'b1, 1'b1, RS_A_CTL, 8'h00, v);
    chk("unselected", v, 8'hAC);
    bus(1'b1, 1'b0, RS_B_CTL, 8'h2C, v);
    bus(1'b1, 1'b0, RS_B_DATA, 8'h22, v);
    chk("cb pulse", {7'h0, cb_out}, 8'h00);
    bus(1'b0, 1'b0, RS_B_CTL, 8'h00, v);
    chk("cb pulse end", {7'h0, cb_out}, 8'h01);
    $display("t_cl_out done");
  endtask
  // A second reset mid-run clears written registers and frees the port A lines and both control lines.
  task automatic t_rst_mid();
    @(posedge clk);
    #5;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #5;
    chk("pa oe mid", pa_oe_n, 8'hFF);
    chk("cl oe mid", {6'h0, ca_oe_n, cb_oe_n}, 8'h03);
    bus(1'b1, 1'b1, RS_B_CTL, 8'h00, v);
    chk("ctl b mid", v, RST_REG);
    bus(1'b0, 1'b1, RS_A_CTL, 8'h00, v);
    chk("unsel oe", {7'h0, oe_seen}, 8'h01);
    $display("t_rst_mid done");
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  // Reset for 12 cycles, then the scenarios in order.
  initial begin
    repeat (12) @(posedge clk);
    #5;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_dir();
    t_flags(0);
    t_flags(1);
    t_cl_out();
    t_rst_mid();
    tally_and_finish();
  end
  // About 60 bus cycles of 12 clocks are expected; allow several times that.
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule // dual_port_parallel_adapter_bench
